// File: rtl/fault_sleep_pkg.sv
// Constants and carrier types shared by the fault and sleep supervisor.
// Assumes a single 100 MHz core clock and synchronous active-low reset.
package fault_sleep_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ             = 100;
   localparam int CLR_MIN_US          = 20;   // Shortest fault-clear pulse
   localparam int CLR_MAX_US          = 40;   // Longest pure fault-clear pulse
   localparam int SLEEP_MAX_US        = 120;  // Beyond this, sleep is certain
   localparam int CLR_MIN_CYC         = CLR_MIN_US * CLK_MHZ;
   localparam int CLR_MAX_CYC         = CLR_MAX_US * CLK_MHZ;
   localparam int SLEEP_ENTRY_DEF_CYC = SLEEP_MAX_US * CLK_MHZ;
   localparam int OC_FILTER_DEF_CYC   = 300;  // Overcurrent filter time, cycles
   localparam int WAKE_DEF_CYC        = 4000; // Wake-ready delay, cycles
   localparam int NUM_BRIDGES         = 4;

   // ------------------------------------------------------------------
   // Interrupt status bit positions
   // ------------------------------------------------------------------
   localparam int EV_SUPPLY = 0;
   localparam int EV_PUMP   = 1;
   localparam int EV_OC     = 2;
   localparam int EV_HEAT   = 3;
   localparam int EV_WIDTH  = 4;

   // ------------------------------------------------------------------
   // Register offsets and reset values
   // ------------------------------------------------------------------
   localparam logic [3:0] REG_STATUS    = 4'h0;  // Live and latched state, RO
   localparam logic [3:0] REG_IRQ_STAT  = 4'h4;  // Sticky events, W1C
   localparam logic [3:0] REG_IRQ_MASK  = 4'h8;  // Event enables
   localparam logic [3:0] REG_CTRL      = 4'hC;  // Bridge enables
   localparam logic [3:0] MASK_RESET    = 4'h0;
   localparam logic [3:0] CTRL_RESET    = 4'hF;

   // ------------------------------------------------------------------
   // Mode states and carriers
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_OFF   = 4'h1,   // Main supply locked out, logic held reset
      ST_WAKE  = 4'h2,   // Waking, inputs not yet accepted
      ST_RUN   = 4'h4,   // Active operation
      ST_SLEEP = 4'h8    // Low-power sleep
   } mode_e;

   typedef struct packed {
      logic       supplyLow;
      logic       pumpLow;
      logic [3:0] ocLimit;
      logic       overheat;
   } fault_in_s;

   typedef struct packed {
      logic [3:0] bridgeEn;
      logic       pumpEn;
      logic       regulatorEn;
      logic       logicEn;
   } power_out_s;

endpackage : fault_sleep_pkg

// File: rtl/oc_filter.sv
// One overcurrent filter and latch for a single half-bridge.
// Assumes the current-limit flag is synchronous to core_clk.
module oc_filter
   import fault_sleep_pkg::*;
#(
   parameter int FILTER_CYC = OC_FILTER_DEF_CYC
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // Control
   input  wire logic limitActive,
   input  wire logic clearLatch,
   // Result
   output logic      tripped
);

   localparam int CW = $clog2(FILTER_CYC + 1);
   localparam logic [CW-1:0] LIMIT = CW'(FILTER_CYC);

   initial begin
      if (FILTER_CYC < 1) $error("FILTER_CYC must be at least 1");
   end

   logic [CW-1:0] cntFf;

   // Count consecutive cycles of active current limit
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cntFf <= '0;
      end else if (!limitActive) begin
         cntFf <= '0;
      end else if (cntFf != LIMIT) begin
         cntFf <= cntFf + CW'(1);
      end
   end

   // Latch; a new trip wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tripped <= 1'b0;
      end else if (limitActive && cntFf == LIMIT) begin
         tripped <= 1'b1;  // RULE6
      end else if (clearLatch) begin
         tripped <= 1'b0;  // RULE7
      end
   end

endmodule // oc_filter

// File: rtl/fault_and_sleep_supervisor.sv
// Fault and sleep supervisor for a quad half-bridge driver.
// Assumes all inputs are synchronous to core_clk and analog comparators
// are outside; the open-drain fault pin is resolved by the surroundings.
//
// Functional notes
// RULE1: Any fault drives fault output low; in ST_SLEEP the code drives it only for supply lockout
// RULE2: No fault after power-up releases output
// RULE3: Supply lockout kills outputs, pump, asserts fault
// RULE4: Supply recovery resumes automatically
// RULE5: Pump lockout kills outputs, pump keeps running
// RULE6: Filtered overcurrent disables its own bridge
// RULE7: Overcurrent latched until pulse or power cycle
// RULE8: Overheat disables every output, asserts fault; the code asserts fault for it only outside ST_SLEEP
// RULE9: Overheat latched until pulse or power cycle
// RULE10: Sleep input low means everything off
// RULE11: Sleep only after the entry delay
// RULE12: Wake on high; wait wake delay
// RULE13: Active needs sleep high and supply good; the code also goes from ST_WAKE to ST_RUN when sleep goes low
// RULE14: Pulse of 20 to 40 us clears faults
// RULE15: Pulse of 40 to 120 us clears too
// RULE16: Clear pulse leaves pump and blocks alone
// RULE17: All faults ORed onto one output; in ST_SLEEP the code ORs in only supply lockout
//
// Strobed register access and the register addresses are this design's own decisions.
module fault_and_sleep_supervisor
   import fault_sleep_pkg::*;
#(
   parameter int OC_FILTER_CYC   = OC_FILTER_DEF_CYC,
   parameter int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DEF_CYC,
   parameter int WAKE_CYC        = WAKE_DEF_CYC
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // Pins from the controller and the analog front end
   input  wire logic       sleep_in_low,
   input  wire fault_in_s  faultIn,
   // Open-drain fault pin
   output logic            fault_out_low,
   output logic            faultOe,
   // Power and drive enables
   output power_out_s      powerOut,
   output logic            inputsReady,
   // Register port
   input  wire logic [3:0] regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic [31:0]     regRdata,
   // Interrupt
   output logic            irq
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   initial begin
      if (SLEEP_ENTRY_CYC <= CLR_MAX_CYC) $error("Sleep entry must exceed clear window");
      if (WAKE_CYC < 1) $error("WAKE_CYC must be at least 1");
   end

   localparam int LW = $clog2(SLEEP_ENTRY_CYC + 1);
   localparam int WW = $clog2(WAKE_CYC + 1);
   localparam logic [LW-1:0] SLEEP_LIM = LW'(SLEEP_ENTRY_CYC);
   localparam logic [LW-1:0] CLR_LIM   = LW'(CLR_MIN_CYC);
   localparam logic [WW-1:0] WAKE_LIM  = WW'(WAKE_CYC);

   mode_e         modeFf;
   mode_e         nxt_mode;
   logic [LW-1:0] lowCntFf;
   logic [WW-1:0] wakeCntFf;
   logic          sleepPrevFf;
   logic          heatLatchFf;
   logic [3:0]    ocTrip;
   logic [3:0]    ocTripPrevFf;
   logic          heatPrevFf;
   logic          supplyPrevFf;
   logic          pumpPrevFf;
   logic [3:0]    irqStatFf;
   logic [3:0]    irqMaskFf;
   logic [3:0]    ctrlFf;
   logic          clearPulse;
   logic          anyFault;
   logic [3:0]    events;

   // ------------------------------------------------------------------
   // Sleep input pulse measurement
   // ------------------------------------------------------------------
   // Low time saturates at the sleep limit so the counter never wraps
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         lowCntFf <= '0;
      end else if (sleep_in_low) begin
         lowCntFf <= '0;
      end else if (lowCntFf != SLEEP_LIM) begin
         lowCntFf <= lowCntFf + LW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sleepPrevFf <= 1'b1;
      end else begin
         sleepPrevFf <= sleep_in_low;
      end
   end

   // A rising edge after at least 20 us low clears latches. Pulses in the
   // 40 to 120 us band also clear, and then sleep entry is not reached.
   assign clearPulse = sleep_in_low && !sleepPrevFf && lowCntFf >= CLR_LIM; // RULE14 RULE15

   // ------------------------------------------------------------------
   // Latched faults
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BRIDGES; gi++) begin : g_oc
         oc_filter #(
            .FILTER_CYC (OC_FILTER_CYC)
         ) u_oc (
            .core_clk    (core_clk),
            .nrst        (nrst),
            .limitActive (faultIn.ocLimit[gi] && modeFf == ST_RUN),
            .clearLatch  (clearPulse || modeFf == ST_OFF),
            .tripped     (ocTrip[gi])
         );
      end
   endgenerate

   // Overheat stays latched after cooling; a new event beats a clear
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         heatLatchFf <= 1'b0;
      end else if (faultIn.overheat) begin
         heatLatchFf <= 1'b1;  // RULE8
      end else if (clearPulse || modeFf == ST_OFF) begin
         heatLatchFf <= 1'b0;  // RULE9
      end
   end

   // ------------------------------------------------------------------
   // Mode state machine
   // ------------------------------------------------------------------
   always_comb begin
      nxt_mode = modeFf;
      case (modeFf)
         ST_OFF: begin
            if (!faultIn.supplyLow && sleep_in_low) nxt_mode = ST_WAKE; // RULE4 RULE13
         end
         ST_WAKE: begin
            if (faultIn.supplyLow) nxt_mode = ST_OFF;
            else if (!sleep_in_low) nxt_mode = ST_RUN;
            else if (wakeCntFf == WAKE_LIM) nxt_mode = ST_RUN;
         end
         ST_RUN: begin
            if (faultIn.supplyLow) nxt_mode = ST_OFF;  // RULE3
            else if (!sleep_in_low && lowCntFf == SLEEP_LIM) nxt_mode = ST_SLEEP; // RULE11
         end
         ST_SLEEP: begin
            if (faultIn.supplyLow) nxt_mode = ST_OFF;
            else if (sleep_in_low) nxt_mode = ST_WAKE;  // RULE12
         end
         default: nxt_mode = ST_OFF;
      endcase
   end

   // Waking from sleep clears latches, since the rising sleep edge is a clear pulse (also cleared on power loss)
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         modeFf <= ST_OFF;
      end else begin
         modeFf <= nxt_mode;
      end
   end

   // Wake-ready counter runs only in the wake state
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wakeCntFf <= '0;
      end else if (modeFf != ST_WAKE) begin
         wakeCntFf <= '0;
      end else if (wakeCntFf != WAKE_LIM) begin
         wakeCntFf <= wakeCntFf + WW'(1);
      end
   end

   // WAKE exits to RUN, but inputs only ready once the wake delay passed
   logic wakeDoneFf;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wakeDoneFf <= 1'b0;
      end else if (modeFf == ST_WAKE) begin
         wakeDoneFf <= (wakeCntFf == WAKE_LIM);
      end else if (modeFf != ST_RUN) begin
         wakeDoneFf <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Fault pin and enables
   // ------------------------------------------------------------------
   // Supply lockout resets logic, so it is reported regardless of mode
   assign anyFault = faultIn.supplyLow || (modeFf != ST_SLEEP &&
                     (faultIn.pumpLow || heatLatchFf || (|ocTrip))); // RULE17

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         fault_out_low <= 1'b1;  // RULE2
         faultOe       <= 1'b0;
      end else begin
         fault_out_low <= 1'b0;
         faultOe       <= anyFault;  // RULE1
      end
   end

   // Clear pulse touches only latches; pump and regulator follow mode
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         powerOut <= '0;
      end else begin
         powerOut.logicEn     <= nxt_mode != ST_OFF && nxt_mode != ST_SLEEP; // RULE10
         powerOut.regulatorEn <= nxt_mode != ST_SLEEP && !faultIn.supplyLow;
         powerOut.pumpEn      <= (nxt_mode == ST_RUN || nxt_mode == ST_WAKE) &&
                                 !faultIn.supplyLow && !heatLatchFf && !faultIn.overheat; // RULE3 RULE5 RULE16
         if (nxt_mode == ST_RUN && !faultIn.pumpLow && !faultIn.overheat && !heatLatchFf) begin
            powerOut.bridgeEn <= ctrlFf & ~ocTrip;  // RULE5 RULE6 RULE8
         end else begin
            powerOut.bridgeEn <= '0;  // RULE3 RULE10
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         inputsReady <= 1'b0;
      end else begin
         inputsReady <= modeFf == ST_RUN && nxt_mode == ST_RUN && wakeDoneFf; // RULE12
      end
   end

   // ------------------------------------------------------------------
   // Interrupt events and register port
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         supplyPrevFf <= 1'b0;
         pumpPrevFf   <= 1'b0;
         heatPrevFf   <= 1'b0;
         ocTripPrevFf <= '0;
      end else begin
         supplyPrevFf <= faultIn.supplyLow;
         pumpPrevFf   <= faultIn.pumpLow;
         heatPrevFf   <= heatLatchFf;
         ocTripPrevFf <= ocTrip;
      end
   end

   always_comb begin
      events            = '0;
      events[EV_SUPPLY] = faultIn.supplyLow && !supplyPrevFf;
      events[EV_PUMP]   = faultIn.pumpLow && !pumpPrevFf;
      events[EV_OC]     = |(ocTrip & ~ocTripPrevFf);
      events[EV_HEAT]   = heatLatchFf && !heatPrevFf;
   end

   // Write-one-to-clear; a new event in the same cycle wins
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irqStatFf <= '0;
      end else begin
         if (regWr && regAddr == REG_IRQ_STAT) begin
            irqStatFf <= (irqStatFf & ~regWdata[EV_WIDTH-1:0]) | events;
         end else begin
            irqStatFf <= irqStatFf | events;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irqMaskFf <= MASK_RESET;
         ctrlFf    <= CTRL_RESET;
      end else if (regWr) begin
         if (regAddr == REG_IRQ_MASK) irqMaskFf <= regWdata[EV_WIDTH-1:0];
         if (regAddr == REG_CTRL) ctrlFf <= regWdata[NUM_BRIDGES-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatFf & irqMaskFf);
      end
   end

   // Read data valid one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         regRdata <= '0;
      end else if (regRd) begin
         case (regAddr)
            REG_STATUS:   regRdata <= {16'h0000, 4'(modeFf), ocTrip, 3'h0, heatLatchFf,
                                       faultIn.overheat, faultIn.pumpLow,
                                       faultIn.supplyLow, anyFault};
            REG_IRQ_STAT: regRdata <= {28'h0000000, irqStatFf};
            REG_IRQ_MASK: regRdata <= {28'h0000000, irqMaskFf};
            REG_CTRL:     regRdata <= {28'h0000000, ctrlFf};
            default:      regRdata <= 32'h00000000;
         endcase
      end else begin
         regRdata <= 32'h00000000;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_fault_pin;
      @(posedge core_clk) disable iff (!nrst) anyFault |=> faultOe && !fault_out_low;
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("Fault not driven"); // RULE1

   property p_supply_off;
      @(posedge core_clk) disable iff (!nrst)
         faultIn.supplyLow |=> powerOut.bridgeEn == 4'h0 && !powerOut.pumpEn;
   endproperty
   a_supply_off: assert property (p_supply_off) else $error("Supply lockout leak"); // RULE3

   property p_pump_kept;
      @(posedge core_clk) disable iff (!nrst)
         (modeFf == ST_RUN && nxt_mode == ST_RUN && faultIn.pumpLow && !heatLatchFf &&
          !faultIn.overheat) |=> powerOut.pumpEn && powerOut.bridgeEn == 4'h0;
   endproperty
   a_pump_kept: assert property (p_pump_kept) else $error("Pump lockout wrong"); // RULE5

   property p_oc_off;
      @(posedge core_clk) disable iff (!nrst) ocTrip[1] |=> !powerOut.bridgeEn[1];
   endproperty
   a_oc_off: assert property (p_oc_off) else $error("Tripped bridge on"); // RULE6

   property p_oc_hold;
      @(posedge core_clk) disable iff (!nrst)
         ocTrip[1] && !clearPulse && modeFf != ST_OFF |=> ocTrip[1];
   endproperty
   a_oc_hold: assert property (p_oc_hold) else $error("Trip lost"); // RULE7

   property p_heat_hold;
      @(posedge core_clk) disable iff (!nrst)
         heatLatchFf && !clearPulse && modeFf != ST_OFF |=> heatLatchFf;
   endproperty
   a_heat_hold: assert property (p_heat_hold) else $error("Overheat lost"); // RULE9

   property p_sleep_off;
      @(posedge core_clk) disable iff (!nrst)
         modeFf == ST_SLEEP && nxt_mode == ST_SLEEP |=> powerOut == '0;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("Sleep not off"); // RULE10

   sequence s_short_low;
      sleep_in_low ##1 !sleep_in_low [*8] ##1 sleep_in_low;
   endsequence
   property p_no_early_sleep;
      @(posedge core_clk) disable iff (!nrst) s_short_low |-> modeFf != ST_SLEEP;
   endproperty
   a_no_early_sleep: assert property (p_no_early_sleep) else $error("Early sleep"); // RULE11

   property p_clear;
      @(posedge core_clk) disable iff (!nrst)
         clearPulse && !faultIn.overheat |=> !heatLatchFf;
   endproperty
   a_clear: assert property (p_clear) else $error("Clear pulse ignored"); // RULE14

endmodule // fault_and_sleep_supervisor

// File: verif/sleep_ctrl_model.sv
// Behavioural model of the external controller that owns the sleep pin.
// Assumes it is clocked by core_clk; the bench asks it for low pulses.
module sleep_ctrl_model
   import fault_sleep_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Pulse request from the bench
   input  wire logic        pulseGo,
   input  wire logic [15:0] pulseLen,
   // Pin side
   output logic             sleep_in_low,
   output logic             busy
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] lowCnt_ff;

   // ----------------------------------------------------------------
   // Pulse timer
   // ----------------------------------------------------------------
   // Push-pull pin, so it is never left floating; high while idle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         lowCnt_ff <= 16'h0;
      end else if (pulseGo) begin
         lowCnt_ff <= pulseLen;
      end else if (lowCnt_ff != 16'h0) begin
         lowCnt_ff <= lowCnt_ff - 16'h1;
      end
   end

   // Pin low exactly for the requested count
   assign sleep_in_low = (lowCnt_ff == 16'h0);
   assign busy         = (lowCnt_ff != 16'h0);
endmodule // sleep_ctrl_model

// File: verif/fault_and_sleep_supervisor_tb.sv
// Self-checking bench for the fault and sleep supervisor.
// Assumes short filter and wake counts; sleep entry at 4100 cycles.
module fault_and_sleep_supervisor_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import fault_sleep_pkg::*;

   localparam int SLP = 4100;

   logic        core_clk;
   logic        nrst;
   logic        sleep_in_low;
   fault_in_s   faultIn;
   logic        fault_out_low;
   logic        faultOe;
   power_out_s  powerOut;
   logic        inputsReady;
   logic [3:0]  regAddr;
   logic [31:0] regWdata;
   logic        regWr;
   logic        regRd;
   logic [31:0] regRdata;
   logic        irq;
   logic        pulseGo;
   logic [15:0] pulseLen;
   logic        busy;
   wire         faultPin = faultOe ? 1'b0 : 1'b1; // Pull-up resolves the pin
   int          miscompares;
   int          checks_done;

   fault_and_sleep_supervisor #(.OC_FILTER_CYC(4), .SLEEP_ENTRY_CYC(SLP), .WAKE_CYC(5))
      u_fault_and_sleep_supervisor (.core_clk(core_clk), .nrst(nrst),
      .sleep_in_low(sleep_in_low), .faultIn(faultIn), .fault_out_low(fault_out_low),
      .faultOe(faultOe), .powerOut(powerOut), .inputsReady(inputsReady),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .irq(irq));

   sleep_ctrl_model u_sleep_ctrl_model (.core_clk(core_clk), .nrst(nrst),
      .pulseGo(pulseGo), .pulseLen(pulseLen), .sleep_in_low(sleep_in_low), .busy(busy));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Waits n edges, then lets that edge's updates settle
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr    <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge core_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd   <= 1'b0;
      #1;
      chk(what, regRdata, exp);
   endtask

   task automatic pulse(input int len);
      @(posedge core_clk);
      pulseGo  <= 1'b1;
      pulseLen <= 16'(len);
      @(posedge core_clk);
      pulseGo  <= 1'b0;
   endtask

   // Bounded wait for the wake delay to finish
   task automatic waitReady();
      int n;
      n = 0;
      while (inputsReady !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 200) begin
         miscompares++;
         close_out();
      end
   endtask

   // Pin level, bridge enables and pump enable in one go
   task automatic state(input logic pin, input logic [3:0] br, input logic pump);
      chk("fault pin", 32'(faultPin), 32'(pin));
      chk("bridges", 32'(powerOut.bridgeEn), 32'(br));
      chk("pump", 32'(powerOut.pumpEn), 32'(pump));
   endtask

   // ----------------------------------------------------------------
   // Clock, reset and watchdog
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      miscompares++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      faultIn = '0;
      regAddr = 4'h0;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      pulseGo = 1'b0;
      pulseLen = 16'h0;
      miscompares = 0;
      checks_done = 0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      // Power-up with clean supply: released pin, full drive
      waitReady();
      state(1'b1, 4'hF, 1'b1);
      chk("regulator", 32'(powerOut.regulatorEn), 32'h1);
      chk("data", 32'(fault_out_low), 32'h0);
      chk("logic on", 32'(powerOut.logicEn), 32'h1);
      rd(REG_STATUS, 32'h4000, "status run");
      rd(REG_IRQ_MASK, 32'(MASK_RESET), "mask reset");
      rd(REG_CTRL, 32'(CTRL_RESET), "ctrl reset");
      rd(4'h2, 32'h0, "unmapped");
      // Bridge enable register gates the drive
      wr(REG_CTRL, 32'h7);
      cyc(2);
      chk("ctrl bridges", 32'(powerOut.bridgeEn), 32'h7);
      wr(REG_CTRL, 32'hF);
      // Supply lockout and automatic recovery
      @(posedge core_clk) faultIn.supplyLow <= 1'b1;
      cyc(4);
      state(1'b0, 4'h0, 1'b0);
      @(posedge core_clk) faultIn.supplyLow <= 1'b0;
      waitReady();
      state(1'b1, 4'hF, 1'b1);
      // Pump lockout, masked then unmasked interrupt
      @(posedge core_clk) faultIn.pumpLow <= 1'b1;
      cyc(4);
      state(1'b0, 4'h0, 1'b1);
      chk("irq masked", 32'(irq), 32'h0);
      @(posedge core_clk) faultIn.pumpLow <= 1'b0;
      cyc(4);
      state(1'b1, 4'hF, 1'b1);
      wr(REG_IRQ_MASK, 32'h2);
      cyc(3);
      chk("irq on", 32'(irq), 32'h1);
      rd(REG_IRQ_STAT, 32'h3, "irq stat");
      wr(REG_IRQ_STAT, 32'h2);
      cyc(3);
      chk("irq clear", 32'(irq), 32'h0);
      // A very short low pulse neither sleeps nor disturbs the drive
      pulse(8);
      cyc(12);
      state(1'b1, 4'hF, 1'b1);
      // Overcurrent shorter than the filter is ignored
      @(posedge core_clk) faultIn.ocLimit <= 4'h2;
      cyc(3);
      @(posedge core_clk) faultIn.ocLimit <= 4'h0;
      cyc(4);
      state(1'b1, 4'hF, 1'b1);
      // Filtered overcurrent trips its own bridge and stays latched
      @(posedge core_clk) faultIn.ocLimit <= 4'h2;
      cyc(9);
      @(posedge core_clk) faultIn.ocLimit <= 4'h0;
      cyc(4);
      state(1'b0, 4'hD, 1'b1);
      pulse(1000);
      cyc(1005);
      state(1'b0, 4'hD, 1'b1);
      // Clear pulse leaves the pump running throughout
      pulse(2500);
      cyc(2400);
      chk("pump in pulse", 32'(powerOut.pumpEn), 32'h1);
      cyc(110);
      state(1'b1, 4'hF, 1'b1);
      rd(REG_STATUS, 32'h4000, "status after clear");
      // Overheat latch, cleared by the short and the long pulse
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk) faultIn.overheat <= 1'b1;
         cyc(4);
         state(1'b0, 4'h0, 1'b0);
         @(posedge core_clk) faultIn.overheat <= 1'b0;
         cyc(6);
         state(1'b0, 4'h0, 1'b0);
         pulse(i == 0 ? 3000 : 4050);
         cyc((i == 0 ? 3000 : 4050) + 8);
         waitReady();
         state(1'b1, 4'hF, 1'b1);
      end
      // Long low: no sleep before the entry delay, all off after it
      pulse(5000);
      cyc(SLP - 100);
      chk("pump pre sleep", 32'(powerOut.pumpEn), 32'h1);
      cyc(300);
      chk("all off", 32'(powerOut), 32'h0);
      cyc(1000);
      waitReady();
      state(1'b1, 4'hF, 1'b1);
      close_out();
   end
endmodule // fault_and_sleep_supervisor_tb
